// ==== rtl/e1tx_pkg.sv ====
// Operation
// - ts16_y_force sets bit 6 of TS16, signaling frame 0; else sent 0
// - all_ones_force replaces every transmitted bit with 1
// - Plain framing: Si bit 1 into FAS bit 1, bit 0 into NFAS
// - CRC generation with remote error indication ignores both Si bits
// - CRC, indication off, insertion on: Si bits into frames 13 and 15
// - CRC, indication off, insertion off: spare bits come from backplane
// - Extra bits go to TS16 bits 5, 7, 8 of signaling frame 0
// - Each enable bit gates its status flag onto irq_out_n
// - frame_flag set at timeslot 30 bit 7 of every frame
// - submf_flag set at timeslot 30 bit 7 of submultiframe frame 0
// - crc_mf_flag set at timeslot 30 bit 7 of multiframe frame 0
// - nfas_flag set at timeslot 30 bit 7 of every NFAS frame
// - sig_mf_flag set at timeslot 14 bit 1 of signaling frame 0
// - Reading the status register returns flags then clears them
// - Codeword select: 011 Sa4, 100 Sa5, 101 Sa6, 110 Sa7; low undefined
// - Registers held in reset while e1_mode_select is 0
// - Code 111 selects Sa8 with codeword bits in reverse order
// - intl_insert_disable takes TS0 international, national bits from pcm
// - Extra bits inserted only when extra_insert_disable is 0
package e1tx_pkg;
  localparam int PADDR_W = 12;
  localparam logic [9:0] IDX_CONFIG = 10'h080;
  localparam logic [9:0] IDX_ALARM = 10'h081;
  localparam logic [9:0] IDX_INTL = 10'h082;
  localparam logic [9:0] IDX_EXTRA = 10'h083;
  localparam logic [9:0] IDX_IRQ_EN = 10'h084;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h085;
  localparam logic [9:0] IDX_SA_SEL = 10'h086;
  localparam logic [9:0] IDX_CODEWORD = 10'h087;
  localparam logic [7:0] RST_CONFIG = 8'h60;
  localparam logic [7:0] RST_ALARM = 8'h00;
  localparam logic [7:0] RST_INTL = 8'hC0;
  localparam logic [7:0] RST_EXTRA = 8'h0B;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_SA_SEL = 8'h60;
  localparam logic [7:0] RST_CODEWORD = 8'h0F;
  localparam logic [7:0] MASK_ALARM = 8'h07;
  localparam logic [7:0] MASK_INTL = 8'hC0;
  localparam logic [7:0] MASK_EXTRA = 8'h0B;
  localparam logic [7:0] MASK_IRQ = 8'h1F;
  localparam logic [7:0] MASK_SA_SEL = 8'hE0;
  localparam int CFG_SIG_EN = 6;
  localparam int CFG_CRC_GEN = 4;
  localparam int CFG_FRAMING_DIS = 3;
  localparam int CFG_REI_DIS = 2;
  localparam int CFG_INTL_DIS = 1;
  localparam int CFG_EXTRA_DIS = 0;
  localparam int ALM_Y_FORCE = 2;
  localparam int ALM_ALL_ONES = 0;
  localparam int INTL_SI1 = 7;
  localparam int INTL_SI0 = 6;
  localparam int EXTRA_X1 = 3;
  localparam int EXTRA_X3 = 1;
  localparam int EXTRA_X4 = 0;
  localparam int SEL_LSB = 5;
  localparam int FLAG_FRAME = 0;
  localparam int FLAG_SUBMF = 1;
  localparam int FLAG_CRC_MF = 2;
  localparam int FLAG_NFAS = 3;
  localparam int FLAG_SIG_MF = 4;
  localparam logic [4:0] TS_OVERHEAD = 5'h00;
  localparam logic [4:0] TS_SIG_FLAG = 5'h0E;
  localparam logic [4:0] TS_CAS = 5'h10;
  localparam logic [4:0] TS_FLAG = 5'h1E;
  localparam logic [2:0] BIT_FLAG = 3'h6;
  localparam logic [2:0] BIT_Y = 3'h5;
  localparam logic [2:0] BIT_X1 = 3'h4;
  localparam logic [2:0] BIT_X3 = 3'h6;
  localparam logic [2:0] BIT_X4 = 3'h7;
  localparam logic [2:0] BIT_SPOILER = 3'h1;
  localparam logic [2:0] BIT_REMOTE = 3'h2;
  localparam logic [2:0] SA_FIRST = 3'h3;
  localparam logic [2:0] SA_REVERSED = 3'h7;
  localparam logic [6:0] FAS_PATTERN = 7'h1B;
  localparam logic [5:0] MFAS_PATTERN = 6'h0B;
  localparam logic [2:0] MF_SPARE_A = 3'h6;
endpackage

// ==== rtl/e1tx_sync.sv ====
`timescale 1ns/1ns
module e1tx_sync #(
  parameter int WIDTH = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // Stage one feeds only stage two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// ==== rtl/e1tx_position.sv ====
`timescale 1ns/1ns
module e1tx_position (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frame_start,
  output logic [2:0] bit_idx,
  output logic [4:0] timeslot,
  output logic [3:0] frame
);
  logic [11:0] count;
  logic [11:0] next_count;
  logic [11:0] here;

  // A start pulse marks bit 1 of TS0 in frame 0; 4096 bits wrap to it
  always_comb begin
    here = frame_start ? 12'h000 : count;
    next_count = here + 12'h001;
    {frame, timeslot, bit_idx} = here;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 12'h000;
    end else begin
      count <= next_count;
    end
  end
endmodule

// ==== rtl/e1tx_top.sv ====
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
module e1tx_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [e1tx_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic e1_mode_select,
  input wire logic backplane_tx_pcm,
  input wire logic backplane_frame_sync,
  output logic line_tx_data,
  output logic irq_out_n
);
  logic [2:0] pin_sync;
  logic mode_on;
  logic pcm_in;
  logic frame_start;
  logic [2:0] b;
  logic [4:0] ts;
  logic [3:0] fr;

  logic [7:0] config_reg, alarm_reg, intl_bit_control, extra_bit_control;
  logic [7:0] tx_irq_enable, national_codeword_select, codeword;
  logic [7:0] codeword_live;
  logic [4:0] tx_irq_status;
  logic [7:0] next_config, next_alarm, next_intl, next_extra;
  logic [7:0] next_irq_en, next_sa_sel, next_codeword, next_cw_live;
  logic [4:0] next_status;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_line, next_irq_n;
  logic [4:0] flag_set;
  logic [7:0] rd_byte;
  logic mapped, setup_phase, access, wr_en, stat_rd;

  logic [2:0] sa_sel;
  logic [1:0] cw_k;
  logic cw_value, cw_enable, sa_valid;
  logic fas, crc_gen, intl_dis, rei_dis;

  e1tx_sync #(.WIDTH(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({e1_mode_select, backplane_tx_pcm, backplane_frame_sync}),
    .sync_out(pin_sync)
  );

  assign mode_on = pin_sync[2];
  assign pcm_in = pin_sync[1];
  assign frame_start = pin_sync[0];

  e1tx_position u_pos (
    .pclk(pclk),
    .presetn(presetn),
    .frame_start(frame_start),
    .bit_idx(b),
    .timeslot(ts),
    .frame(fr)
  );

  function automatic logic at_index(input logic [e1tx_pkg::PADDR_W-1:0] a,
                                    input logic [9:0] idx);
    at_index = (a == {idx, 2'b00});
  endfunction

  assign setup_phase = psel && !penable;
  assign access = psel && penable && pready;
  assign sa_sel = national_codeword_select[e1tx_pkg::SEL_LSB +: 3];
  assign fas = !fr[0];
  assign crc_gen = config_reg[e1tx_pkg::CFG_CRC_GEN];
  assign intl_dis = config_reg[e1tx_pkg::CFG_INTL_DIS];
  assign rei_dis = config_reg[e1tx_pkg::CFG_REI_DIS];

  // Read decode; status captured at setup, so clear uses what was shown
  always_comb begin
    mapped = 1'b1;
    rd_byte = 8'h00;
    if (at_index(paddr, e1tx_pkg::IDX_CONFIG)) begin
      rd_byte = config_reg;
    end else if (at_index(paddr, e1tx_pkg::IDX_ALARM)) begin
      rd_byte = alarm_reg;
    end else if (at_index(paddr, e1tx_pkg::IDX_INTL)) begin
      rd_byte = intl_bit_control;
    end else if (at_index(paddr, e1tx_pkg::IDX_EXTRA)) begin
      rd_byte = extra_bit_control;
    end else if (at_index(paddr, e1tx_pkg::IDX_IRQ_EN)) begin
      rd_byte = tx_irq_enable;
    end else if (at_index(paddr, e1tx_pkg::IDX_IRQ_STAT)) begin
      rd_byte = {3'h0, tx_irq_status};
    end else if (at_index(paddr, e1tx_pkg::IDX_SA_SEL)) begin
      rd_byte = national_codeword_select;
    end else if (at_index(paddr, e1tx_pkg::IDX_CODEWORD)) begin
      rd_byte = codeword;
    end else begin
      mapped = 1'b0;
    end
  end

  // Codeword slot within a submultiframe and its bit for the chosen Sa
  always_comb begin
    cw_k = fr[2:1];
    sa_valid = (sa_sel >= e1tx_pkg::SA_FIRST);
    cw_enable = codeword_live[3'h7 - {1'b0, cw_k}];
    if (sa_sel == e1tx_pkg::SA_REVERSED) begin
      cw_value = codeword_live[{1'b0, cw_k}];
    end else begin
      cw_value = codeword_live[3'h3 - {1'b0, cw_k}];
    end
  end

  // Transmit stream overhead insertion
  always_comb begin
    next_line = pcm_in;
    if (alarm_reg[e1tx_pkg::ALM_ALL_ONES]) begin
      next_line = 1'b1;
    end else if (!config_reg[e1tx_pkg::CFG_FRAMING_DIS]) begin
      if (ts == e1tx_pkg::TS_OVERHEAD && fas) begin
        if (b == 3'h0) begin
          // FAS international bit; CRC bits pass through
          if (!crc_gen && !intl_dis) begin
            next_line = intl_bit_control[e1tx_pkg::INTL_SI1];
          end
        end else begin
          next_line = e1tx_pkg::FAS_PATTERN[3'h7 - b];
        end
      end else if (ts == e1tx_pkg::TS_OVERHEAD) begin
        if (b == 3'h0) begin
          if (!crc_gen) begin
            if (!intl_dis) begin
              next_line = intl_bit_control[e1tx_pkg::INTL_SI0];
            end
          end else if (fr[3:1] < e1tx_pkg::MF_SPARE_A) begin
            next_line = e1tx_pkg::MFAS_PATTERN[3'h5 - fr[3:1]];
          end else if (!rei_dis) begin
            // Si ignored, no far-end errors reported
            next_line = 1'b1;
          end else if (!intl_dis) begin
            // spare bits of frames 13 and 15
            next_line = (fr[3:1] == e1tx_pkg::MF_SPARE_A) ?
                        intl_bit_control[e1tx_pkg::INTL_SI1] :
                        intl_bit_control[e1tx_pkg::INTL_SI0];
          end
          // both disables keep the backplane bit
        end else if (b == e1tx_pkg::BIT_SPOILER) begin
          next_line = 1'b1;
        end else if (b == e1tx_pkg::BIT_REMOTE) begin
          next_line = 1'b0;
        end else if (!intl_dis && sa_valid && b == sa_sel && cw_enable) begin
          // selected national bit carries the codeword
          next_line = cw_value;
        end
        // with insertion off the national bits stay from pcm
      end else if (ts == e1tx_pkg::TS_CAS && fr == 4'h0 &&
                   config_reg[e1tx_pkg::CFG_SIG_EN]) begin
        if (b == e1tx_pkg::BIT_Y) begin
          next_line = alarm_reg[e1tx_pkg::ALM_Y_FORCE];
        end else if (!config_reg[e1tx_pkg::CFG_EXTRA_DIS]) begin
          // extra bits into TS16 only when enabled
          if (b == e1tx_pkg::BIT_X1) begin
            next_line = extra_bit_control[e1tx_pkg::EXTRA_X1];
          end else if (b == e1tx_pkg::BIT_X3) begin
            next_line = extra_bit_control[e1tx_pkg::EXTRA_X3];
          end else if (b == e1tx_pkg::BIT_X4) begin
            next_line = extra_bit_control[e1tx_pkg::EXTRA_X4];
          end
        end
      end
    end
  end

  // Boundary events
  always_comb begin
    flag_set = 5'h00;
    if (ts == e1tx_pkg::TS_FLAG && b == e1tx_pkg::BIT_FLAG) begin
      flag_set[e1tx_pkg::FLAG_FRAME] = 1'b1;
      flag_set[e1tx_pkg::FLAG_SUBMF] = (fr[2:0] == 3'h0);
      flag_set[e1tx_pkg::FLAG_CRC_MF] = (fr == 4'h0);
      flag_set[e1tx_pkg::FLAG_NFAS] = fr[0];
    end
    if (ts == e1tx_pkg::TS_SIG_FLAG && b == 3'h0 && fr == 4'h0) begin
      flag_set[e1tx_pkg::FLAG_SIG_MF] = 1'b1;
    end
  end

  // Register file and bus answer
  always_comb begin
    wr_en = access && pwrite && mapped;
    stat_rd = access && !pwrite && at_index(paddr, e1tx_pkg::IDX_IRQ_STAT);
    next_config = config_reg;
    next_alarm = alarm_reg;
    next_intl = intl_bit_control;
    next_extra = extra_bit_control;
    next_irq_en = tx_irq_enable;
    next_sa_sel = national_codeword_select;
    next_codeword = codeword;
    next_cw_live = codeword_live;
    if (wr_en && at_index(paddr, e1tx_pkg::IDX_CONFIG)) begin
      next_config = pwdata[7:0];
    end
    if (wr_en && at_index(paddr, e1tx_pkg::IDX_ALARM)) begin
      next_alarm = pwdata[7:0] & e1tx_pkg::MASK_ALARM;
    end
    if (wr_en && at_index(paddr, e1tx_pkg::IDX_INTL)) begin
      next_intl = pwdata[7:0] & e1tx_pkg::MASK_INTL;
    end
    if (wr_en && at_index(paddr, e1tx_pkg::IDX_EXTRA)) begin
      next_extra = pwdata[7:0] & e1tx_pkg::MASK_EXTRA;
    end
    if (wr_en && at_index(paddr, e1tx_pkg::IDX_IRQ_EN)) begin
      next_irq_en = pwdata[7:0] & e1tx_pkg::MASK_IRQ;
    end
    if (wr_en && at_index(paddr, e1tx_pkg::IDX_SA_SEL)) begin
      next_sa_sel = pwdata[7:0] & e1tx_pkg::MASK_SA_SEL;
    end
    if (wr_en && at_index(paddr, e1tx_pkg::IDX_CODEWORD)) begin
      next_codeword = pwdata[7:0];
    end
    // Codeword reloads only at submultiframe start to avoid a torn word
    if (ts == e1tx_pkg::TS_OVERHEAD && b == 3'h0 && fr[2:0] == 3'h0) begin
      next_cw_live = codeword;
    end
    // read clears shown bits; a new event wins over the clear
    next_status = tx_irq_status | flag_set;
    if (stat_rd) begin
      next_status = (tx_irq_status & ~prdata[4:0]) | flag_set;
    end
    // held in reset outside E1 mode
    if (!mode_on) begin
      next_config = e1tx_pkg::RST_CONFIG;
      next_alarm = e1tx_pkg::RST_ALARM;
      next_intl = e1tx_pkg::RST_INTL;
      next_extra = e1tx_pkg::RST_EXTRA;
      next_irq_en = e1tx_pkg::RST_IRQ_EN;
      next_sa_sel = e1tx_pkg::RST_SA_SEL;
      next_codeword = e1tx_pkg::RST_CODEWORD;
      next_cw_live = e1tx_pkg::RST_CODEWORD;
      next_status = 5'h00;
    end
    next_irq_n = ~|(next_status & next_irq_en[4:0]);
    next_pready = setup_phase;
    next_pslverr = setup_phase && !mapped;
    next_prdata = setup_phase ? {24'h00_0000, rd_byte} : prdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= e1tx_pkg::RST_CONFIG;
      alarm_reg <= e1tx_pkg::RST_ALARM;
      intl_bit_control <= e1tx_pkg::RST_INTL;
      extra_bit_control <= e1tx_pkg::RST_EXTRA;
      tx_irq_enable <= e1tx_pkg::RST_IRQ_EN;
      national_codeword_select <= e1tx_pkg::RST_SA_SEL;
      codeword <= e1tx_pkg::RST_CODEWORD;
      codeword_live <= e1tx_pkg::RST_CODEWORD;
      tx_irq_status <= 5'h00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      line_tx_data <= 1'b1;
      irq_out_n <= 1'b1;
    end else begin
      config_reg <= next_config;
      alarm_reg <= next_alarm;
      intl_bit_control <= next_intl;
      extra_bit_control <= next_extra;
      tx_irq_enable <= next_irq_en;
      national_codeword_select <= next_sa_sel;
      codeword <= next_codeword;
      codeword_live <= next_cw_live;
      tx_irq_status <= next_status;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      line_tx_data <= next_line;
      irq_out_n <= next_irq_n;
    end
  end

  a_all_ones_out: assert property (@(posedge pclk)
    disable iff (!presetn)
    alarm_reg[e1tx_pkg::ALM_ALL_ONES] |=> line_tx_data)
    else $error("all ones alarm not on line");

  a_y_bit_value: assert property (@(posedge pclk)
    disable iff (!presetn)
    (!alarm_reg[0] && !config_reg[3] && config_reg[6] && ts == 5'h10 &&
     fr == 4'h0 && b == 3'h5)
    |=> line_tx_data == $past(alarm_reg[2]))
    else $error("Y bit does not follow its control");

  a_fas_intl_bit: assert property (@(posedge pclk)
    disable iff (!presetn)
    (config_reg[4:0] == 5'h00 && alarm_reg[0] == 1'b0 && ts == 5'h00 &&
     !fr[0] && b == 3'h0) |=> line_tx_data == $past(intl_bit_control[7]))
    else $error("FAS international bit wrong");

  a_frame_flag_set: assert property (@(posedge pclk)
    disable iff (!presetn)
    (mode_on && ts == 5'h1E && b == 3'h6) |=> tx_irq_status[0])
    else $error("frame flag not set at timeslot 30");

  a_sig_mf_flag: assert property (@(posedge pclk)
    disable iff (!presetn)
    (mode_on && ts == 5'h0E && b == 3'h0 && fr == 4'h0)
    |=> tx_irq_status[4])
    else $error("signaling multiframe flag missing");

  a_status_read_clear: assert property (@(posedge pclk)
    disable iff (!presetn)
    (stat_rd && flag_set == 5'h00)
    |=> (tx_irq_status & $past(prdata[4:0])) == 5'h00)
    else $error("status read did not clear");

  a_irq_pin_level: assert property (@(posedge pclk)
    disable iff (!presetn)
    irq_out_n == !(|(tx_irq_status & tx_irq_enable[4:0])))
    else $error("interrupt pin disagrees with flags");

  a_mode_hold_reset: assert property (@(posedge pclk)
    disable iff (!presetn)
    !mode_on |=> (tx_irq_enable == 8'h00 && tx_irq_status == 5'h00 &&
                  intl_bit_control == 8'hC0))
    else $error("registers not held outside E1 mode");

  a_rei_spare_bit: assert property (@(posedge pclk)
    disable iff (!presetn)
    (config_reg[4:2] == 3'b100 && alarm_reg[0] == 1'b0 && ts == 5'h00 &&
     fr == 4'hD && b == 3'h0) |=> line_tx_data)
    else $error("Si used while error indication on");

  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("bus answer timing wrong");
endmodule

// ==== bench/e1tx_pcm_src.sv ====
`timescale 1ns/1ns
module e1tx_pcm_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level,
  output logic pcm,
  output logic fsync,
  output logic [11:0] pos
);
  logic [11:0] next_pos;
  always_comb begin
    next_pos = pos + 12'h001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= 12'h000;
    end else begin
      pos <= next_pos;
    end
  end
  // Pulse marks TS0 bit 1 of frame 0, so the bench can map line bits
  assign fsync = (pos == 12'h000);
  assign pcm = level;
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, line_tx_data, irq_out_n, pcm, fsync, err;
  logic e1_mode_select = 1'b1;
  logic level = 1'b0;
  logic [11:0] pos;
  logic [7:0] rd;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [9:0] ri [7] = '{e1tx_pkg::IDX_CONFIG, e1tx_pkg::IDX_ALARM,
    e1tx_pkg::IDX_INTL, e1tx_pkg::IDX_EXTRA, e1tx_pkg::IDX_IRQ_EN,
    e1tx_pkg::IDX_SA_SEL, e1tx_pkg::IDX_CODEWORD};
  logic [7:0] rst [7] = '{e1tx_pkg::RST_CONFIG, e1tx_pkg::RST_ALARM,
    e1tx_pkg::RST_INTL, e1tx_pkg::RST_EXTRA, e1tx_pkg::RST_IRQ_EN,
    e1tx_pkg::RST_SA_SEL, e1tx_pkg::RST_CODEWORD};
  // Alarm write keeps the reserved bit at 0
  logic [7:0] wv [7] = '{8'hFF, 8'h05, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] rb [7] = '{8'hFF, 8'h05, e1tx_pkg::MASK_INTL,
    e1tx_pkg::MASK_EXTRA, e1tx_pkg::MASK_IRQ, e1tx_pkg::MASK_SA_SEL, 8'hFF};
  // Line position one bit before each flag's setting point
  logic [11:0] fo [5] = '{12'h0F5, 12'h0F5, 12'h0F5, 12'h0F5, 12'h06F};

  always #4 pclk = ~pclk;

  e1tx_top e1tx_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .e1_mode_select(e1_mode_select), .backplane_tx_pcm(pcm),
    .backplane_frame_sync(fsync), .line_tx_data(line_tx_data),
    .irq_out_n(irq_out_n));
  e1tx_pcm_src e1tx_pcm_src_i (.pclk(pclk), .presetn(presetn),
    .level(level), .pcm(pcm), .fsync(fsync), .pos(pos));

  task automatic give_verdict();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic stall();
    n_mismatch++;
    give_verdict();
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // Request stays put until the edge that samples pready high
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) stall();
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [9:0] idx,
                      input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(nm, rd, e);
  endtask

  // Waits until the line shows bit b of timeslot t in frame f
  task automatic at(input int f, t, b);
    int n;
    logic [11:0] lp;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
      if (n > 9000) stall();
      lp = pos - 12'h003;
    end while (lp !== 12'(f * 256 + t * 8 + b - 1));
  endtask

  task automatic lchk(input string nm, input int f, t, b, input logic e);
    at(f, t, b);
    chk(nm, {7'h00, line_tx_data}, {7'h00, e});
  endtask

  task automatic setup(input logic [7:0] c, al, si, x, input logic l);
    apb(1'b1, e1tx_pkg::IDX_CONFIG, c);
    apb(1'b1, e1tx_pkg::IDX_ALARM, al);
    apb(1'b1, e1tx_pkg::IDX_INTL, si);
    apb(1'b1, e1tx_pkg::IDX_EXTRA, x);
    level <= l;
  endtask

  function automatic logic frame_ok(input int i, input logic [3:0] f);
    case (i)
      0: return 1'b1;
      1: return f[2:0] == 3'h0;
      3: return f[0];
      default: return f == 4'h0;
    endcase
  endfunction

  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      rchk("reset value", ri[i], rst[i]);
      apb(1'b1, ri[i], wv[i]);
      rchk("readback", ri[i], rb[i]);
      apb(1'b1, ri[i], rst[i]);
    end
    apb(1'b0, 10'h0FF, 8'h00);
    chk("unmapped err", {7'h00, err}, 8'h01);
    chk("unmapped data", rd, 8'h00);
  endtask

  task automatic t_mode();
    apb(1'b1, e1tx_pkg::IDX_INTL, 8'h00);
    e1_mode_select <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b1, e1tx_pkg::IDX_INTL, 8'h40);
    rchk("intl held", e1tx_pkg::IDX_INTL, e1tx_pkg::RST_INTL);
    e1_mode_select <= 1'b1;
    repeat (4) @(posedge pclk);
    rchk("intl after", e1tx_pkg::IDX_INTL, e1tx_pkg::RST_INTL);
  endtask

  task automatic t_ts0();
    for (int s = 1; s < 3; s++) begin
      setup(8'h60, 8'h00, {s[1:0], 6'h00}, 8'h0B, 1'b1);
      lchk("fas si", 0, 0, 1, s[1]);
      lchk("nfas si", 1, 0, 1, s[0]);
    end
    setup(8'h62, 8'h00, 8'h00, 8'h0B, 1'b1);
    lchk("fas pcm", 0, 0, 1, 1'b1);
    lchk("nfas pcm", 1, 0, 1, 1'b1);
    setup(8'h74, 8'h00, 8'h80, 8'h0B, 1'b1);
    lchk("spare 13", 13, 0, 1, 1'b1);
    lchk("spare 15", 15, 0, 1, 1'b0);
    setup(8'h70, 8'h00, 8'h00, 8'h0B, 1'b0);
    lchk("rei 13", 13, 0, 1, 1'b1);
    lchk("rei 15", 15, 0, 1, 1'b1);
    setup(8'h76, 8'h00, 8'hC0, 8'h0B, 1'b0);
    lchk("pcm 13", 13, 0, 1, 1'b0);
    lchk("pcm 15", 15, 0, 1, 1'b0);
  endtask

  task automatic t_ts16();
    setup(8'h60, 8'h04, 8'hC0, 8'h0A, 1'b0);
    lchk("x1", 0, 16, 5, 1'b1);
    lchk("y on", 0, 16, 6, 1'b1);
    lchk("x3", 0, 16, 7, 1'b1);
    lchk("x4", 0, 16, 8, 1'b0);
    setup(8'h61, 8'h00, 8'hC0, 8'h0A, 1'b1);
    lchk("y off", 0, 16, 6, 1'b0);
    lchk("x4 pcm", 0, 16, 8, 1'b1);
    setup(8'h60, 8'h01, 8'hC0, 8'h0B, 1'b0);
    lchk("ais fas", 0, 0, 2, 1'b1);
    lchk("ais data", 0, 5, 3, 1'b1);
    // Framing off: the FAS pattern bit comes from the backplane
    setup(8'h68, 8'h00, 8'hC0, 8'h0B, 1'b1);
    lchk("framing_disable fas", 0, 0, 2, 1'b1);
  endtask

  task automatic t_sa();
    setup(8'h60, 8'h00, 8'hC0, 8'h0B, 1'b0);
    apb(1'b1, e1tx_pkg::IDX_CODEWORD, 8'hF8);
    for (int c = 0; c < 8; c++) begin
      at(0, 0, 1);
      apb(1'b1, e1tx_pkg::IDX_SA_SEL, {c[2:0], 5'h00});
      lchk("sa first", 9, 0, c > 2 ? c + 1 : 4, c > 2 && c < 7);
      lchk("sa last", 15, 0, c > 2 ? c + 1 : 4, c == 7);
    end
  endtask

  task automatic t_irq();
    int n;
    logic [11:0] q;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, e1tx_pkg::IDX_IRQ_EN, 8'(1 << i));
      apb(1'b0, e1tx_pkg::IDX_IRQ_STAT, 8'h00);
      repeat (2) @(posedge pclk);
      #1;
      chk("irq released", {7'h00, irq_out_n}, 8'h01);
      n = 0;
      while (irq_out_n !== 1'b0) begin
        n++;
        if (n > 5000) stall();
        @(posedge pclk);
        #1;
      end
      q = pos - 12'h003 - fo[i];
      // A wrong enable or position makes the pin fall elsewhere
      chk("flag pos", {7'h00, q[7:0] < 8'h04 && frame_ok(i, q[11:8])},
          8'h01);
      apb(1'b0, e1tx_pkg::IDX_IRQ_STAT, 8'h00);
      chk("flag set", {7'h00, rd[i]}, 8'h01);
      apb(1'b0, e1tx_pkg::IDX_IRQ_STAT, 8'h00);
      chk("flag clear", {7'h00, rd[i]}, 8'h00);
    end
    apb(1'b1, e1tx_pkg::IDX_IRQ_EN, 8'h00);
    apb(1'b0, e1tx_pkg::IDX_IRQ_STAT, 8'h00);
    n = 0;
    repeat (600) begin
      @(posedge pclk);
      #1;
      n += (irq_out_n !== 1'b1);
    end
    chk("masked pin", 8'(n), 8'h00);
    apb(1'b0, e1tx_pkg::IDX_IRQ_STAT, 8'h00);
    chk("masked flag", {7'h00, rd[0]}, 8'h01);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_mode();
    t_ts0();
    t_ts16();
    t_sa();
    t_irq();
    give_verdict();
  end

  initial begin
    repeat (98000) @(posedge pclk);
    stall();
  end
endmodule
